// [logic/ipcb_defines.vh]
// Register offsets, field positions, reset values and masks for the priority bank
`ifndef IPCB_DEFINES_VH
`define IPCB_DEFINES_VH

`define IPCB_NUM_REGS       8
`define IPCB_ADDR_W         5
`define IPCB_OFS_UART2      5'h00
`define IPCB_OFS_SPI2       5'h04
`define IPCB_OFS_CAPTURE    5'h08
`define IPCB_OFS_COMPARE    5'h0C
`define IPCB_OFS_PARPORT    5'h10
`define IPCB_OFS_I2C2       5'h14
`define IPCB_OFS_EXTIRQ     5'h18
`define IPCB_OFS_RTC        5'h1C

`define IPCB_FLD_HI         12
`define IPCB_FLD_MID        8
`define IPCB_FLD_LO4        4
`define IPCB_FLD_LO0        0
`define IPCB_FIELD_RESET    3'h4
`define IPCB_SRC_EN_RESET   20'hFFFFF

`define IPCB_MASK_UART2     16'h7777
`define IPCB_MASK_SPI2      16'h0077
`define IPCB_MASK_CAPTURE   16'h7770
`define IPCB_MASK_COMPARE   16'h7777
`define IPCB_MASK_PARPORT   16'h0077
`define IPCB_MASK_I2C2      16'h0770
`define IPCB_MASK_EXTIRQ    16'h0770
`define IPCB_MASK_RTC       16'h0700

`define IPCB_RESP_OKAY      2'h0
`define IPCB_RESP_SLVERR    2'h2

`endif

// [logic/ipcb_priority_reg.v]
// One 16-bit priority register with implemented-bit mask and per-field reset
`timescale 1ns/100ps
`include "ipcb_defines.vh"

module ipcb_priority_reg #(
  parameter [15:0] IMPL_MASK = 16'hFFFF
) (
  input  wire        clock,    // System clock
  input  wire        resetn,   // Async reset, active low
  input  wire        wr_en,    // Write strobe for this register
  input  wire [15:0] wr_data,  // Write data, already merged with byte strobes
  output wire [15:0] rd_data   // Stored value, unimplemented bits zero
);

  reg [15:0] value_r;

  // Upper bit of each implemented field is one at reset, so level four
  localparam [15:0] RESET_VAL = IMPL_MASK & {4{1'b0, `IPCB_FIELD_RESET}};

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      value_r <= RESET_VAL;
    end else if (wr_en) begin
      value_r <= wr_data & IMPL_MASK;
    end
  end

  assign rd_data = value_r & IMPL_MASK;

endmodule

// [logic/ipcb_bank.v]
// Interrupt priority bank: AXI4-Lite slave holding eight priority registers
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
`include "ipcb_defines.vh"

module ipcb_bank (
  input  wire        clock,                   // System clock, 100 MHz
  input  wire        resetn,                  // Async reset, active low
  input  wire [4:0]  s_axi_awaddr,            // Write address
  input  wire [2:0]  s_axi_awprot,            // Write protection, unused
  input  wire        s_axi_awvalid,           // Write address valid
  output wire        s_axi_awready,           // Write address ready
  input  wire [31:0] s_axi_wdata,             // Write data
  input  wire [3:0]  s_axi_wstrb,             // Write byte strobes
  input  wire        s_axi_wvalid,            // Write data valid
  output wire        s_axi_wready,            // Write data ready
  output wire [1:0]  s_axi_bresp,             // Write response
  output wire        s_axi_bvalid,            // Write response valid
  input  wire        s_axi_bready,            // Write response ready
  input  wire [4:0]  s_axi_araddr,            // Read address
  input  wire [2:0]  s_axi_arprot,            // Read protection, unused
  input  wire        s_axi_arvalid,           // Read address valid
  output wire        s_axi_arready,           // Read address ready
  output wire [31:0] s_axi_rdata,             // Read data
  output wire [1:0]  s_axi_rresp,             // Read response
  output wire        s_axi_rvalid,            // Read data valid
  input  wire        s_axi_rready,            // Read data ready
  output wire [2:0]  uart2_tx_priority,       // Priority level toward arbiter
  output wire [2:0]  uart2_rx_priority,       // Priority level toward arbiter
  output wire [2:0]  ext_irq2_priority,       // Priority level toward arbiter
  output wire [2:0]  timer5_priority,         // Priority level toward arbiter
  output wire [2:0]  spi2_event_priority,     // Priority level toward arbiter
  output wire [2:0]  spi2_fault_priority,     // Priority level toward arbiter
  output wire [2:0]  capture5_priority,       // Priority level toward arbiter
  output wire [2:0]  capture4_priority,       // Priority level toward arbiter
  output wire [2:0]  capture3_priority,       // Priority level toward arbiter
  output wire [2:0]  compare7_priority,       // Priority level toward arbiter
  output wire [2:0]  compare6_priority,       // Priority level toward arbiter
  output wire [2:0]  compare5_priority,       // Priority level toward arbiter
  output wire [2:0]  capture6_priority,       // Priority level toward arbiter
  output wire [2:0]  parallel_port_priority,  // Priority level toward arbiter
  output wire [2:0]  compare8_priority,       // Priority level toward arbiter
  output wire [2:0]  i2c2_master_priority,    // Priority level toward arbiter
  output wire [2:0]  i2c2_slave_priority,     // Priority level toward arbiter
  output wire [2:0]  ext_irq4_priority,       // Priority level toward arbiter
  output wire [2:0]  ext_irq3_priority,       // Priority level toward arbiter
  output wire [2:0]  rtc_calendar_priority,   // Priority level toward arbiter
  output wire [19:0] source_enabled           // High where field is not 000
);

  // Write channel: address and data latched independently in either order
  reg        aw_held_r;
  reg [4:0]  aw_addr_r;
  reg        w_held_r;
  reg [31:0] w_data_r;
  reg [3:0]  w_strb_r;
  reg        bvalid_r;
  reg [1:0]  bresp_r;
  reg        rvalid_r;
  reg [31:0] rdata_r;
  reg [1:0]  rresp_r;

  wire [15:0] reg_rd [0:7];
  wire [7:0]  reg_wr;
  wire [15:0] wr_word [0:7];
  wire [15:0] reg_nxt [0:7];
  reg  [15:0] rd_word;
  reg  [19:0] src_en_r;
  wire [19:0] src_en_nxt;
  wire        wr_fire;
  wire [2:0]  wr_index;
  wire        wr_valid_addr;
  wire [2:0]  rd_index;
  wire        rd_valid_addr;
  wire        rd_fire;

  // Address word index from bits 4:2; the low two bits only feed the alignment check
  function [2:0] word_index;
    input [4:0] addr;
    begin
      word_index = addr[4:2];
    end
  endfunction

  // Unaligned byte addresses are answered as unmapped
  function addr_ok;
    input [4:0] addr;
    begin
      addr_ok = (addr[1:0] == 2'h0);
    end
  endfunction

  // Byte lanes 1:0 carry the register; the upper half of the bus word is dropped
  function [15:0] merge_bytes;
    input [15:0] old_val;
    input [31:0] data;
    input [3:0]  strb;
    begin
      merge_bytes = {(strb[1] ? data[15:8] : old_val[15:8]),
                     (strb[0] ? data[7:0]  : old_val[7:0])};
    end
  endfunction

  // Three-bit level field whose lowest bit sits at lsb
  function [2:0] field_at;
    input [15:0]  val;
    input integer lsb;
    begin
      field_at = val[lsb +: 3];
    end
  endfunction

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign wr_fire       = aw_held_r && w_held_r && !bvalid_r;
  assign wr_index      = word_index(aw_addr_r);
  assign wr_valid_addr = addr_ok(aw_addr_r);

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 5'h00;
      w_held_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `IPCB_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_valid_addr ? `IPCB_RESP_OKAY : `IPCB_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // Each register only stores its masked bits, so stray writes are harmless
  assign reg_wr[0]  = wr_fire && wr_valid_addr && (wr_index == 3'h0);
  assign wr_word[0] = merge_bytes(reg_rd[0], w_data_r, w_strb_r) & `IPCB_MASK_UART2;
  assign reg_nxt[0] = reg_wr[0] ? wr_word[0] : reg_rd[0];
  ipcb_priority_reg #(
    .IMPL_MASK (`IPCB_MASK_UART2)
  ) reg_uart2_i (
    .clock   (clock),
    .resetn  (resetn),
    .wr_en   (reg_wr[0]),
    .wr_data (wr_word[0]),
    .rd_data (reg_rd[0])
  );

  assign reg_wr[1]  = wr_fire && wr_valid_addr && (wr_index == 3'h1);
  assign wr_word[1] = merge_bytes(reg_rd[1], w_data_r, w_strb_r) & `IPCB_MASK_SPI2;
  assign reg_nxt[1] = reg_wr[1] ? wr_word[1] : reg_rd[1];
  ipcb_priority_reg #(
    .IMPL_MASK (`IPCB_MASK_SPI2)
  ) reg_spi2_i (
    .clock   (clock),
    .resetn  (resetn),
    .wr_en   (reg_wr[1]),
    .wr_data (wr_word[1]),
    .rd_data (reg_rd[1])
  );

  assign reg_wr[2]  = wr_fire && wr_valid_addr && (wr_index == 3'h2);
  assign wr_word[2] = merge_bytes(reg_rd[2], w_data_r, w_strb_r) & `IPCB_MASK_CAPTURE;
  assign reg_nxt[2] = reg_wr[2] ? wr_word[2] : reg_rd[2];
  ipcb_priority_reg #(
    .IMPL_MASK (`IPCB_MASK_CAPTURE)
  ) reg_capture_i (
    .clock   (clock),
    .resetn  (resetn),
    .wr_en   (reg_wr[2]),
    .wr_data (wr_word[2]),
    .rd_data (reg_rd[2])
  );

  assign reg_wr[3]  = wr_fire && wr_valid_addr && (wr_index == 3'h3);
  assign wr_word[3] = merge_bytes(reg_rd[3], w_data_r, w_strb_r) & `IPCB_MASK_COMPARE;
  assign reg_nxt[3] = reg_wr[3] ? wr_word[3] : reg_rd[3];
  ipcb_priority_reg #(
    .IMPL_MASK (`IPCB_MASK_COMPARE)
  ) reg_compare_i (
    .clock   (clock),
    .resetn  (resetn),
    .wr_en   (reg_wr[3]),
    .wr_data (wr_word[3]),
    .rd_data (reg_rd[3])
  );

  assign reg_wr[4]  = wr_fire && wr_valid_addr && (wr_index == 3'h4);
  assign wr_word[4] = merge_bytes(reg_rd[4], w_data_r, w_strb_r) & `IPCB_MASK_PARPORT;
  assign reg_nxt[4] = reg_wr[4] ? wr_word[4] : reg_rd[4];
  ipcb_priority_reg #(
    .IMPL_MASK (`IPCB_MASK_PARPORT)
  ) reg_parport_i (
    .clock   (clock),
    .resetn  (resetn),
    .wr_en   (reg_wr[4]),
    .wr_data (wr_word[4]),
    .rd_data (reg_rd[4])
  );

  assign reg_wr[5]  = wr_fire && wr_valid_addr && (wr_index == 3'h5);
  assign wr_word[5] = merge_bytes(reg_rd[5], w_data_r, w_strb_r) & `IPCB_MASK_I2C2;
  assign reg_nxt[5] = reg_wr[5] ? wr_word[5] : reg_rd[5];
  ipcb_priority_reg #(
    .IMPL_MASK (`IPCB_MASK_I2C2)
  ) reg_i2c2_i (
    .clock   (clock),
    .resetn  (resetn),
    .wr_en   (reg_wr[5]),
    .wr_data (wr_word[5]),
    .rd_data (reg_rd[5])
  );

  assign reg_wr[6]  = wr_fire && wr_valid_addr && (wr_index == 3'h6);
  assign wr_word[6] = merge_bytes(reg_rd[6], w_data_r, w_strb_r) & `IPCB_MASK_EXTIRQ;
  assign reg_nxt[6] = reg_wr[6] ? wr_word[6] : reg_rd[6];
  ipcb_priority_reg #(
    .IMPL_MASK (`IPCB_MASK_EXTIRQ)
  ) reg_extirq_i (
    .clock   (clock),
    .resetn  (resetn),
    .wr_en   (reg_wr[6]),
    .wr_data (wr_word[6]),
    .rd_data (reg_rd[6])
  );

  assign reg_wr[7]  = wr_fire && wr_valid_addr && (wr_index == 3'h7);
  assign wr_word[7] = merge_bytes(reg_rd[7], w_data_r, w_strb_r) & `IPCB_MASK_RTC;
  assign reg_nxt[7] = reg_wr[7] ? wr_word[7] : reg_rd[7];
  ipcb_priority_reg #(
    .IMPL_MASK (`IPCB_MASK_RTC)
  ) reg_rtc_i (
    .clock   (clock),
    .resetn  (resetn),
    .wr_en   (reg_wr[7]),
    .wr_data (wr_word[7]),
    .rd_data (reg_rd[7])
  );

  // Read channel: one outstanding read, data registered
  assign s_axi_arready = !rvalid_r;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign rd_index      = word_index(s_axi_araddr);
  assign rd_valid_addr = addr_ok(s_axi_araddr);

  // Read word select; an unaligned address returns zero
  always @* begin
    rd_word = 16'h0000;
    case (rd_index)
      3'h0:    rd_word = reg_rd[0];
      3'h1:    rd_word = reg_rd[1];
      3'h2:    rd_word = reg_rd[2];
      3'h3:    rd_word = reg_rd[3];
      3'h4:    rd_word = reg_rd[4];
      3'h5:    rd_word = reg_rd[5];
      3'h6:    rd_word = reg_rd[6];
      3'h7:    rd_word = reg_rd[7];
      default: rd_word = 16'h0000;
    endcase
    if (!rd_valid_addr) begin
      rd_word = 16'h0000;
    end
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `IPCB_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rdata_r  <= {16'h0000, rd_word};
      rresp_r  <= rd_valid_addr ? `IPCB_RESP_OKAY : `IPCB_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

  // Field outputs come straight from the stored flops: visible the cycle after the write
  assign uart2_tx_priority      = reg_rd[0][14:12];
  assign uart2_rx_priority      = reg_rd[0][10:8];
  assign ext_irq2_priority      = reg_rd[0][6:4];
  assign timer5_priority        = reg_rd[0][2:0];
  assign spi2_event_priority    = reg_rd[1][6:4];
  assign spi2_fault_priority    = reg_rd[1][2:0];
  assign capture5_priority      = reg_rd[2][14:12];
  assign capture4_priority      = reg_rd[2][10:8];
  assign capture3_priority      = reg_rd[2][6:4];
  assign compare7_priority      = reg_rd[3][14:12];
  assign compare6_priority      = reg_rd[3][10:8];
  assign compare5_priority      = reg_rd[3][6:4];
  assign capture6_priority      = reg_rd[3][2:0];
  assign parallel_port_priority = reg_rd[4][6:4];
  assign compare8_priority      = reg_rd[4][2:0];
  assign i2c2_master_priority   = reg_rd[5][10:8];
  assign i2c2_slave_priority    = reg_rd[5][6:4];
  assign ext_irq4_priority      = reg_rd[6][10:8];
  assign ext_irq3_priority      = reg_rd[6][6:4];
  assign rtc_calendar_priority  = reg_rd[7][10:8];

  // Level code is the binary value itself; 000 removes the source from arbitration
  function lvl_on;
    input [2:0] lvl;
    begin
      lvl_on = (lvl != 3'h0);
    end
  endfunction

  // Enables come from the next register values so that they move with the levels
  assign src_en_nxt = {
    lvl_on(field_at(reg_nxt[7], `IPCB_FLD_MID)), lvl_on(field_at(reg_nxt[6], `IPCB_FLD_LO4)),
    lvl_on(field_at(reg_nxt[6], `IPCB_FLD_MID)), lvl_on(field_at(reg_nxt[5], `IPCB_FLD_LO4)),
    lvl_on(field_at(reg_nxt[5], `IPCB_FLD_MID)), lvl_on(field_at(reg_nxt[4], `IPCB_FLD_LO0)),
    lvl_on(field_at(reg_nxt[4], `IPCB_FLD_LO4)), lvl_on(field_at(reg_nxt[3], `IPCB_FLD_LO0)),
    lvl_on(field_at(reg_nxt[3], `IPCB_FLD_LO4)), lvl_on(field_at(reg_nxt[3], `IPCB_FLD_MID)),
    lvl_on(field_at(reg_nxt[3], `IPCB_FLD_HI)),  lvl_on(field_at(reg_nxt[2], `IPCB_FLD_LO4)),
    lvl_on(field_at(reg_nxt[2], `IPCB_FLD_MID)), lvl_on(field_at(reg_nxt[2], `IPCB_FLD_HI)),
    lvl_on(field_at(reg_nxt[1], `IPCB_FLD_LO0)), lvl_on(field_at(reg_nxt[1], `IPCB_FLD_LO4)),
    lvl_on(field_at(reg_nxt[0], `IPCB_FLD_LO0)), lvl_on(field_at(reg_nxt[0], `IPCB_FLD_LO4)),
    lvl_on(field_at(reg_nxt[0], `IPCB_FLD_MID)), lvl_on(field_at(reg_nxt[0], `IPCB_FLD_HI))
  };

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      src_en_r <= `IPCB_SRC_EN_RESET;
    end else begin
      src_en_r <= src_en_nxt;
    end
  end

  assign source_enabled = src_en_r;

endmodule

// [bench/ipcb_bank_assertions.sv]
// Checker for the priority bank bus handshakes and level outputs
`timescale 1ns/100ps
module ipcb_bank_chk (
  input wire logic        clock,                  // Clock
  input wire logic        resetn,                 // Reset, low
  input wire logic        s_axi_awvalid,          // AW valid
  input wire logic        s_axi_awready,          // AW ready
  input wire logic        s_axi_wvalid,           // W valid
  input wire logic        s_axi_wready,           // W ready
  input wire logic        s_axi_bvalid,           // B valid
  input wire logic        s_axi_bready,           // B ready
  input wire logic [1:0]  s_axi_bresp,            // B code
  input wire logic        s_axi_arvalid,          // AR valid
  input wire logic        s_axi_arready,          // AR ready
  input wire logic        s_axi_rvalid,           // R valid
  input wire logic        s_axi_rready,           // R ready
  input wire logic [31:0] s_axi_rdata,            // R data
  input wire logic [2:0]  uart2_tx_priority,      // Level
  input wire logic [2:0]  timer5_priority,        // Level
  input wire logic [2:0]  rtc_calendar_priority,  // Level
  input wire logic [19:0] source_enabled          // Enables
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence wr_both_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Levels may only move at the edge that completes a write
  sequence lvl_move_s;
    $changed(uart2_tx_priority) || $changed(timer5_priority) || $changed(rtc_calendar_priority);
  endsequence
  rd_zero_bits_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h0 &&
    s_axi_rdata[11] == 1'b0 && s_axi_rdata[7] == 1'b0 && s_axi_rdata[3] == 1'b0)
    else $error("unimplemented read bit set");
  rd_latency_a: assert property (rd_take_s |=> s_axi_rvalid)
    else $error("read answer late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  b_gate_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  ar_gate_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  wr_resp_a: assert property (wr_both_s |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  lvl_quiet_a: assert property (lvl_move_s |-> $rose(s_axi_bvalid))
    else $error("level moved without a write");
  src_off_a: assert property (source_enabled[0] == (uart2_tx_priority != 3'h0) &&
    source_enabled[3] == (timer5_priority != 3'h0) && source_enabled[19] == (rtc_calendar_priority != 3'h0))
    else $error("enable does not follow level");
endmodule
bind ipcb_bank ipcb_bank_chk ipcb_bank_chk_i (
  .clock(clock), .resetn(resetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .uart2_tx_priority(uart2_tx_priority), .timer5_priority(timer5_priority),
  .rtc_calendar_priority(rtc_calendar_priority), .source_enabled(source_enabled));

// [bench/tb.sv]
// Self-checking bench for the priority bank over AXI4-Lite
`timescale 1ns/100ps
`include "ipcb_defines.vh"
module tb;
  typedef struct {logic [4:0] a; logic [15:0] d; logic [3:0] s; logic [15:0] e;} ipcb_row_t;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic [4:0]  s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [2:0]   uart2_tx_priority, uart2_rx_priority, ext_irq2_priority, timer5_priority;
  wire [2:0]   spi2_event_priority, spi2_fault_priority, capture5_priority, capture4_priority;
  wire [2:0]   capture3_priority, compare7_priority, compare6_priority, compare5_priority;
  wire [2:0]   capture6_priority, parallel_port_priority, compare8_priority, i2c2_master_priority;
  wire [2:0]   i2c2_slave_priority, ext_irq4_priority, ext_irq3_priority, rtc_calendar_priority;
  wire [19:0]  source_enabled;
  int          fails = 0;
  int          n_compared = 0;
  logic [15:0] msk [8] = '{16'h7777, 16'h0077, 16'h7770, 16'h7777,
                           16'h0077, 16'h0770, 16'h0770, 16'h0700};
  ipcb_row_t   rows [6] = '{'{`IPCB_OFS_UART2, 16'h0000, 4'h3, 16'h0000},
                            '{`IPCB_OFS_CAPTURE, 16'h0001, 4'h3, 16'h0000},
                            '{`IPCB_OFS_I2C2, 16'hF88F, 4'h3, 16'h0000},
                            '{`IPCB_OFS_COMPARE, 16'h1234, 4'h1, 16'h7734},
                            '{`IPCB_OFS_RTC, 16'h0500, 4'h2, 16'h0500},
                            '{`IPCB_OFS_UART2, 16'h7310, 4'h3, 16'h7310}};
  ipcb_bank ipcb_bank_i (.*);
  initial forever #5 clock = ~clock;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Master holds bready up after a transfer so the next call never assigns it twice
  task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic [3:0] s,
                    input bit stall, input logic [1:0] er);
    logic ta, tw, tk, bs;
    logic [1:0] r;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'hA5A5, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !stall;
    do begin
      #1;
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tk = s_axi_bvalid && s_axi_bready;
      bs = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (bs && !tk) s_axi_bready <= 1'b1;
    end while (!tk);
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic rchk(input logic [4:0] a, input logic [15:0] e, input logic [1:0] er, input bit stall);
    logic ta, tk, rs;
    logic [31:0] d;
    logic [1:0] r;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !stall;
    do begin
      #1;
      ta = s_axi_arvalid && s_axi_arready;
      tk = s_axi_rvalid && s_axi_rready;
      rs = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clock);
      if (ta) s_axi_arvalid <= 1'b0;
      if (rs && !tk) s_axi_rready <= 1'b1;
    end while (!tk);
    chk("rdata", {16'h0, e}, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    chk("reset levels", {6'h0, uart2_tx_priority, rtc_calendar_priority, source_enabled}, 32'h024FFFFF);
    for (int i = 0; i < 8; i++) rchk(5'(i * 4), 16'h4444 & msk[i], `IPCB_RESP_OKAY, 1'b0);
    for (int i = 0; i < 8; i++) begin
      wr(5'(i * 4), 16'hFFFF, 4'h3, i == 2, `IPCB_RESP_OKAY);
      rchk(5'(i * 4), msk[i], `IPCB_RESP_OKAY, i == 5);
    end
    for (int i = 0; i < 6; i++) begin
      wr(rows[i].a, rows[i].d, rows[i].s, 1'b0, `IPCB_RESP_OKAY);
      rchk(rows[i].a, rows[i].e, `IPCB_RESP_OKAY, 1'b0);
    end
    chk("levels", {7'h0, uart2_tx_priority, uart2_rx_priority, ext_irq2_priority, timer5_priority,
        compare5_priority, capture6_priority, rtc_calendar_priority, source_enabled[3:0]},
        {7'h0, 3'h7, 3'h3, 3'h1, 3'h0, 3'h3, 3'h4, 3'h5, 4'h7});
    chk("levels b", {5'h0, spi2_event_priority, spi2_fault_priority, capture5_priority,
        capture4_priority, capture3_priority, compare7_priority, compare6_priority,
        parallel_port_priority, compare8_priority},
        {5'h0, 3'h7, 3'h7, 3'h0, 3'h0, 3'h0, 3'h7, 3'h7, 3'h7, 3'h7});
    chk("levels c", {4'h0, i2c2_master_priority, i2c2_slave_priority, ext_irq4_priority,
        ext_irq3_priority, source_enabled[19:4]},
        {4'h0, 3'h0, 3'h0, 3'h7, 3'h7, 16'hE7E3});
    wr(5'h02, 16'h0000, 4'h3, 1'b0, `IPCB_RESP_SLVERR);
    rchk(`IPCB_OFS_UART2, 16'h7310, `IPCB_RESP_OKAY, 1'b0);
    rchk(5'h03, 16'h0000, `IPCB_RESP_SLVERR, 1'b0);
    resetn <= 1'b0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    chk("rerun level", {29'h0, uart2_tx_priority}, 32'h4);
    rchk(`IPCB_OFS_UART2, 16'h4444, `IPCB_RESP_OKAY, 1'b0);
    give_verdict();
  end
endmodule
